// File: rtl/serial_bus_regs.vh
/*
  Register offsets, field positions, reset values and timing counts of the
  two-wire serial bus block. Assumes inclusion by bare name from rtl/.
*/
`ifndef SERIAL_BUS_REGS_VH
`define SERIAL_BUS_REGS_VH
// ============================================================
// Register byte offsets
`define MODE_OFS 12'h000
`define CTRL_OFS 12'h004
`define SHIFT_OFS 12'h008
`define STAT_OFS 12'h00C
`define FIFO_PUSH_OFS 12'h018
// ============================================================
// Mode register fields
`define MODE_CLKSEL_LSB 0
`define MODE_LINE_B_BIT 2
`define MODE_IF_EN_BIT 3
`define MODE_RESET 4'h0
// ============================================================
// Control register fields
`define CTRL_RELEASE_TRIGGER_BIT 0
`define CTRL_COMMAND_TRIGGER_BIT 1
`define CTRL_ACK_TRIGGER_BIT 2
`define CTRL_AUTO_ACK_ENABLE_BIT 3
`define CTRL_BUSY_OUTPUT_ENABLE_BIT 4
// ============================================================
// Status register fields
`define STAT_RELEASE_DETECTED_BIT 0
`define STAT_COMMAND_DETECTED_BIT 1
`define STAT_ACK_DETECTED_BIT 2
`define STAT_MASKED_BIT 3
`define STAT_SCK_BIT 4
`define STAT_SO_BIT 5
`define STAT_BUSY_BIT 6
// ============================================================
// Clock select codes and divider counts
`define CLK_EXT 2'h0
`define CLK_TIMER 2'h1
`define CLK_DIV16 2'h2
`define CLK_DIV8 2'h3
`define DIV16_HALF 4'h7
`define DIV8_HALF 4'h3
`define BITS_PER_BYTE 4'h8
`endif

// File: rtl/word_fifo.v
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock, asynchronous active-low reset and a clock enable.
*/
module word_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  // Clock and reset
  input wire ref_clk,
  input wire arst_n,
  input wire clk_en,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;
  integer i;

  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem_q[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_q[i] <= {WIDTH{1'b0}};
      end
    end else if (clk_en) begin
      if (push) begin
        mem_q[wr_q] <= in_data;
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // word_fifo

// File: rtl/serial_bus_if.v
/*
  Two-wire serial bus interface with APB register access and a four-word
  transmit FIFO. Assumes one clock ref_clk, pins sampled through three
  flip-flops, open-drain data lines resolved outside with a pull-up.
*/
// Chosen here: the APB register port and the address map.
`include "serial_bus_regs.vh"
module serial_bus_if #(
  parameter FIFO_DEPTH = 4
) (
  // Clock, reset and enable
  input wire ref_clk,
  input wire arst_n,
  input wire clk_en,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Clock sources
  input wire timer_output,
  input wire sck_in,
  output reg sck_out,
  output reg sck_oe,
  // Open-drain data lines
  input wire data_line_a_in,
  input wire data_line_b_in,
  output reg data_line_a_oe,
  output reg data_line_b_oe
);
  // ============================================================
  // Pin synchronisers
  reg [2:0] sck_sync_q;
  reg [2:0] sda_sync_q;
  reg [2:0] sdb_sync_q;
  reg [2:0] tmr_sync_q;
  reg sck_lvl_q;
  reg sda_lvl_q;
  reg tmr_lvl_q;
  wire sel_sda;
  wire sel_sda_mid;
  // ============================================================
  // Registers
  reg [3:0] serial_mode_register_q;
  reg auto_ack_enable_q;
  reg busy_output_enable_q;
  reg ack_trigger_q;
  reg release_detected_q;
  reg command_detected_q;
  reg ack_detected_q;
  reg so_latch_q;
  reg [7:0] shift_register_q;
  reg active_q;
  reg masked_q;
  reg [3:0] bit_cnt_q;
  reg [3:0] div_q;
  reg int_sck_q;
  reg ack_pend_q;
  reg ack_drive_q;
  reg busy_q;
  wire [1:0] clk_sel;
  wire interface_enable;
  wire internal_clk;
  wire sck_now;
  wire sck_rise;
  wire sck_fall;
  wire access_ok;
  wire apb_wr;
  wire apb_rd;
  wire start_req;
  wire fifo_out_valid;
  wire fifo_in_ready;
  wire [7:0] fifo_out_data;
  wire fifo_pop;

  assign clk_sel = serial_mode_register_q[`MODE_CLKSEL_LSB+1:`MODE_CLKSEL_LSB];
  assign interface_enable = serial_mode_register_q[`MODE_IF_EN_BIT];
  assign internal_clk = (clk_sel != `CLK_EXT);
  assign sel_sda = serial_mode_register_q[`MODE_LINE_B_BIT] ? sdb_sync_q[2] : sda_sync_q[2];
  assign sel_sda_mid = serial_mode_register_q[`MODE_LINE_B_BIT] ? sdb_sync_q[1] : sda_sync_q[1];
  assign sck_now = internal_clk ? int_sck_q : sck_lvl_q;
  assign access_ok = interface_enable & masked_q & sck_now;
  assign apb_wr = psel & penable & pwrite & ~pready;
  assign apb_rd = psel & penable & ~pwrite & ~pready;
  // A start waits in the FIFO until the bus is idle with the clock high.
  assign fifo_pop = fifo_out_valid & access_ok & ~active_q;
  assign start_req = fifo_pop;

  // ============================================================
  // Synchronise pins; a level moves once stages two and three agree.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sck_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
      sdb_sync_q <= 3'h7;
      tmr_sync_q <= 3'h0;
      sck_lvl_q <= 1'b1;
      sda_lvl_q <= 1'b1;
      tmr_lvl_q <= 1'b0;
    end else if (clk_en) begin
      sck_sync_q <= {sck_sync_q[1:0], sck_in};
      sda_sync_q <= {sda_sync_q[1:0], data_line_a_in};
      sdb_sync_q <= {sdb_sync_q[1:0], data_line_b_in};
      tmr_sync_q <= {tmr_sync_q[1:0], timer_output};
      if (sck_sync_q[1] == sck_sync_q[2]) begin
        sck_lvl_q <= sck_sync_q[2];
      end
      if (sel_sda_mid == sel_sda) begin
        sda_lvl_q <= sel_sda;
      end
      if (tmr_sync_q[1] == tmr_sync_q[2]) begin
        tmr_lvl_q <= tmr_sync_q[2];
      end
    end
  end

  // ============================================================
  // Serial clock generation and edge detect
  reg sck_prev_q;
  reg sda_prev_q;
  reg tmr_prev_q;
  assign sck_rise = sck_now & ~sck_prev_q;
  assign sck_fall = ~sck_now & sck_prev_q;

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= 4'h0;
      int_sck_q <= 1'b1;
      sck_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      tmr_prev_q <= 1'b0;
    end else if (clk_en) begin
      sck_prev_q <= sck_now;
      sda_prev_q <= sda_lvl_q;
      tmr_prev_q <= tmr_lvl_q;
      if (!active_q) begin
        div_q <= 4'h0;
        int_sck_q <= 1'b1;
      end else if (clk_sel == `CLK_TIMER) begin
        if (tmr_lvl_q && !tmr_prev_q) begin
          int_sck_q <= ~int_sck_q;
        end
      end else if (internal_clk) begin
        if (div_q == ((clk_sel == `CLK_DIV16) ? `DIV16_HALF : `DIV8_HALF)) begin
          div_q <= 4'h0;
          int_sck_q <= ~int_sck_q;
        end else begin
          div_q <= div_q + 4'h1;
        end
      end
    end
  end

  // ============================================================
  // Transfer engine, flags and line drivers
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      serial_mode_register_q <= `MODE_RESET;
      auto_ack_enable_q <= 1'b0;
      busy_output_enable_q <= 1'b0;
      ack_trigger_q <= 1'b0;
      release_detected_q <= 1'b0;
      command_detected_q <= 1'b0;
      ack_detected_q <= 1'b0;
      so_latch_q <= 1'b1;
      shift_register_q <= 8'hFF;
      active_q <= 1'b0;
      masked_q <= 1'b1;
      bit_cnt_q <= 4'h0;
      ack_pend_q <= 1'b0;
      ack_drive_q <= 1'b0;
      busy_q <= 1'b0;
    end else if (clk_en) begin
      if (apb_wr && paddr == `MODE_OFS && !active_q) begin
        serial_mode_register_q <= pwdata[3:0];
      end
      if (apb_wr && paddr == `CTRL_OFS) begin
        auto_ack_enable_q <= pwdata[`CTRL_AUTO_ACK_ENABLE_BIT];
        busy_output_enable_q <= pwdata[`CTRL_BUSY_OUTPUT_ENABLE_BIT];
        if (pwdata[`CTRL_RELEASE_TRIGGER_BIT]) begin
          so_latch_q <= 1'b1;
        end else if (pwdata[`CTRL_COMMAND_TRIGGER_BIT]) begin
          so_latch_q <= 1'b0;
        end
        if (pwdata[`CTRL_ACK_TRIGGER_BIT] && !active_q) begin
          ack_trigger_q <= 1'b1;
        end
      end
      if (apb_wr && paddr == `SHIFT_OFS && access_ok) begin
        shift_register_q <= pwdata[7:0];
      end
      if (start_req) begin
        shift_register_q <= fifo_out_data;
        so_latch_q <= fifo_out_data[7];
        active_q <= 1'b1;
        masked_q <= 1'b0;
        bit_cnt_q <= 4'h0;
        // A byte ended under an internal clock never saw a ninth clock; drop its acknowledge.
        ack_pend_q <= 1'b0;
        busy_q <= 1'b0;
      end else if (active_q && sck_fall && bit_cnt_q != 4'h0) begin
        so_latch_q <= shift_register_q[7];
      end else if (active_q && sck_rise) begin
        shift_register_q <= {shift_register_q[6:0], sda_lvl_q};
        if (bit_cnt_q == `BITS_PER_BYTE - 4'h1) begin
          active_q <= 1'b0;
          masked_q <= 1'b1;
          so_latch_q <= 1'b1;
          ack_pend_q <= 1'b1;
        end
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end
      // Acknowledge and busy run on the ninth and later clocks from the pin.
      if (ack_pend_q && sck_fall && (auto_ack_enable_q || ack_trigger_q)) begin
        ack_drive_q <= 1'b1;
        ack_pend_q <= 1'b0;
        ack_trigger_q <= 1'b0;
      end else if (ack_drive_q && sck_fall) begin
        ack_drive_q <= 1'b0;
        busy_q <= busy_output_enable_q;
      end else if (busy_q && sck_fall && !busy_output_enable_q) begin
        busy_q <= 1'b0;
      end
      // Flags: detection wins over a same-cycle clear.
      if (sck_now && sck_prev_q && sda_lvl_q && !sda_prev_q) begin
        release_detected_q <= 1'b1;
        command_detected_q <= 1'b0;
      end else if (sck_now && sck_prev_q && !sda_lvl_q && sda_prev_q) begin
        command_detected_q <= 1'b1;
      end else if (start_req || !interface_enable) begin
        release_detected_q <= 1'b0;
        command_detected_q <= 1'b0;
      end
      if (sck_rise && !sda_lvl_q && bit_cnt_q == `BITS_PER_BYTE && !active_q) begin
        ack_detected_q <= 1'b1;
        bit_cnt_q <= 4'h0;
      end else if (start_req) begin
        ack_detected_q <= 1'b0;
      end
    end
  end

  // ============================================================
  // Pin outputs; the data pin pulls low when the latch or a control signal wants it.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sck_out <= 1'b1;
      sck_oe <= 1'b0;
      data_line_a_oe <= 1'b0;
      data_line_b_oe <= 1'b0;
    end else if (clk_en) begin
      sck_out <= int_sck_q;
      sck_oe <= interface_enable & internal_clk;
      data_line_a_oe <= interface_enable & ~serial_mode_register_q[`MODE_LINE_B_BIT]
                        & (~so_latch_q | ack_drive_q | busy_q);
      data_line_b_oe <= interface_enable & serial_mode_register_q[`MODE_LINE_B_BIT]
                        & (~so_latch_q | ack_drive_q | busy_q);
    end
  end

  // ============================================================
  // APB slave: one wait state, unmapped addresses answer with an error.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & (paddr != `MODE_OFS) & (paddr != `CTRL_OFS)
                 & (paddr != `SHIFT_OFS) & (paddr != `STAT_OFS)
                 & (paddr != `FIFO_PUSH_OFS);
      prdata <= 32'h00000000;
      if (apb_rd) begin
        case (paddr)
          `MODE_OFS: prdata <= {28'h0000000, serial_mode_register_q};
          `CTRL_OFS: prdata <= {27'h0000000, busy_output_enable_q, auto_ack_enable_q,
                                3'h0};
          `SHIFT_OFS: prdata <= {24'h000000, access_ok ? shift_register_q : 8'h00};
          `STAT_OFS: prdata <= {25'h0000000, busy_q, so_latch_q, sck_now, masked_q,
                                ack_detected_q, command_detected_q, release_detected_q};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ============================================================
  // Transmit FIFO; a write arriving while it is full is dropped.
  word_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(2)
  ) u_tx_fifo (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .in_valid(apb_wr && paddr == `FIFO_PUSH_OFS && interface_enable),
    .in_ready(fifo_in_ready),
    .in_data(pwdata[7:0]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );
endmodule // serial_bus_if

// File: testbench/serial_bus_if_sva.sv
/*
  Checker for the two-wire serial bus block, watching only its ports.
  Assumes one clock ref_clk and the asynchronous active-low reset arst_n.
*/
module serial_bus_if_chk (
  // Clock and reset
  input logic ref_clk,
  input logic arst_n,
  input logic clk_en,
  // APB
  input logic psel,
  input logic penable,
  input logic pready,
  input logic pslverr,
  // Serial pins
  input logic sck_out,
  input logic sck_oe,
  input logic data_line_a_oe,
  input logic data_line_b_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // ============================================================
  // Register bus answer
  AST_PREADY_ONE_WAIT: assert property (psel && penable && !pready && clk_en |=> pready)
    else $error("pready missing one cycle after access");
  AST_PREADY_PULSE: assert property (pready && clk_en |=> !pready)
    else $error("pready longer than one cycle");
  AST_PREADY_CAUSE: assert property ($rose(pready) |-> $past(psel) && $past(penable))
    else $error("pready without access phase");
  AST_SLVERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  // ============================================================
  // Serial side
  AST_ONE_LINE: assert property (!(data_line_a_oe && data_line_b_oe))
    else $error("both data lines driven");
  // An internal divider never gives a half period shorter than three cycles.
  AST_SCK_LOW_WIDTH: assert property (sck_oe && $fell(sck_out) |=> !sck_out [*2])
    else $error("serial clock low phase too short");
  AST_SCK_HIGH_WIDTH: assert property (sck_oe && $rose(sck_out) |=> sck_out [*2])
    else $error("serial clock high phase too short");
  AST_FREEZE: assert property (!clk_en |=> $stable(sck_out) && $stable(sck_oe)
    && $stable(data_line_a_oe) && $stable(data_line_b_oe) && $stable(pready))
    else $error("outputs moved while frozen");
endmodule // serial_bus_if_chk

bind serial_bus_if serial_bus_if_chk i_chk (.ref_clk(ref_clk), .arst_n(arst_n),
  .clk_en(clk_en), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .sck_out(sck_out), .sck_oe(sck_oe), .data_line_a_oe(data_line_a_oe),
  .data_line_b_oe(data_line_b_oe));

// File: testbench/serial_bus_peer.sv
/*
  Far-side bus device: pull-up resolution of both open-drain lines and an
  external serial clock. Assumes the bench calls its tasks between edges.
*/
module serial_bus_peer (
  // Clock
  input logic ref_clk,
  // Block side
  input logic data_line_a_oe,
  input logic data_line_b_oe,
  output logic sck_in,
  output logic data_line_a_in,
  output logic data_line_b_in
);
  logic pull_a = 1'b0;
  logic pull_b = 1'b0;
  initial sck_in = 1'b1;
  // Released lines float to the pull-up level.
  assign data_line_a_in = !(data_line_a_oe || pull_a);
  assign data_line_b_in = !(data_line_b_oe || pull_b);
  // Command: falling data edge while the clock is high.
  task automatic send_command(input bit line_b);
    @(posedge ref_clk);
    sck_in <= 1'b1;
    // The clock must settle high inside the block before the data edge.
    repeat (6) @(posedge ref_clk);
    if (line_b) begin
      pull_b <= 1'b1;
    end else begin
      pull_a <= 1'b1;
    end
  endtask
  // Release: rising data edge while the clock is high.
  task automatic send_release();
    @(posedge ref_clk);
    sck_in <= 1'b1;
    repeat (6) @(posedge ref_clk);
    pull_a <= 1'b0;
    pull_b <= 1'b0;
  endtask
  // Clocks n pulses as master with data MSB first on line a; from the ninth
  // pulse on the line is released so the block can acknowledge and hold busy.
  task automatic clock_byte(input logic [7:0] data, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      sck_in <= 1'b0;
      pull_a <= (i < 8) ? ~data[7 - i] : 1'b0;
      repeat (8) @(posedge ref_clk);
      sck_in <= 1'b1;
      repeat (7) @(posedge ref_clk);
    end
  endtask
  task automatic set_sck(input bit lvl);
    @(posedge ref_clk);
    sck_in <= lvl;
  endtask
endmodule // serial_bus_peer

// File: testbench/serial_bus_if_test.sv
/*
  Self-checking bench: APB master tasks, a peer model on the lines and
  scenarios for triggers, detection, clock select and transfer.
*/
`include "serial_bus_regs.vh"
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin error_cnt++; \
  $display("Error %0t: got %h expected %h", $time, got, exp); end end
module serial_bus_if_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, sck_in, sck_out, sck_oe, la_in, lb_in, la_oe, lb_oe;
  logic [31:0] rd;
  logic err;
  logic [7:0] bits;
  int error_cnt = 0;
  int compares = 0;
  int falls, rises, t0, per;
  always #12.5 ref_clk = ~ref_clk;
  serial_bus_if i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_output(1'b0), .sck_in(sck_in),
    .sck_out(sck_out), .sck_oe(sck_oe), .data_line_a_in(la_in), .data_line_b_in(lb_in),
    .data_line_a_oe(la_oe), .data_line_b_oe(lb_oe));
  serial_bus_peer i_peer (.ref_clk(ref_clk), .data_line_a_oe(la_oe), .data_line_b_oe(lb_oe),
    .sck_in(sck_in), .data_line_a_in(la_in), .data_line_b_in(lb_in));
  task automatic finish_test();
    $display("Comparisons %0d, errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ============================================================
  // APB master: setup, then access held until pready.
  task automatic apb(input bit wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin error_cnt++; finish_test(); end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // ============================================================
  // Runs one byte out on line a and checks count, period and bit order.
  task automatic send_byte(input logic [1:0] sel, input int exp_per);
    logic prev;
    apb(1, `MODE_OFS, 32'h8 | sel);
    apb(1, `FIFO_PUSH_OFS, 32'hA5);
    falls = 0; rises = 0; prev = sck_out; t0 = 0; per = 0;
    for (int c = 0; c < 400; c++) begin
      @(posedge ref_clk); #1;
      if (prev && !sck_out) begin
        falls++;
        if (falls == 1) t0 = c;
        if (falls == 2) per = c - t0;
      end
      if (!prev && sck_out && rises < 8) begin bits[7 - rises] = la_in; rises++; end
      prev = sck_out;
    end
    `CHK(falls, 8)
    `CHK(per, exp_per)
    `CHK(bits, 8'hA5)
    `CHK(sck_oe, 1'b1)
    `CHK(lb_oe, 1'b0)
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    arst_n <= 1'b1;
    apb(0, `MODE_OFS, 0); `CHK(rd[3:0], `MODE_RESET)
    apb(0, 12'h0FC, 0); `CHK(err, 1'b1)
    apb(1, `SHIFT_OFS, 32'h5A); apb(0, `SHIFT_OFS, 0); `CHK(rd[7:0], 8'h00)
    // Command trigger first, so that the release trigger has a low latch to raise.
    apb(1, `CTRL_OFS, 32'h2); apb(0, `STAT_OFS, 0); `CHK(rd[5], 1'b0)
    apb(0, `CTRL_OFS, 0); `CHK(rd[1], 1'b0)
    apb(1, `CTRL_OFS, 32'h1); apb(0, `STAT_OFS, 0); `CHK(rd[5], 1'b1)
    apb(0, `CTRL_OFS, 0); `CHK(rd[0], 1'b0)
    // External clock on line b: the status bit mirrors the pin.
    apb(1, `MODE_OFS, 32'hC);
    i_peer.set_sck(1'b0);
    repeat (8) @(posedge ref_clk);
    apb(0, `STAT_OFS, 0); `CHK(rd[4], 1'b0)
    `CHK(sck_oe, 1'b0)
    i_peer.send_command(1'b1);
    repeat (8) @(posedge ref_clk);
    apb(0, `STAT_OFS, 0); `CHK(rd[1:0], 2'b10)
    i_peer.send_release();
    repeat (8) @(posedge ref_clk);
    apb(0, `STAT_OFS, 0); `CHK(rd[1:0], 2'b01)
    apb(1, `MODE_OFS, 32'h0);
    send_byte(`CLK_DIV16, 16);
    send_byte(`CLK_DIV8, 8);
    // Clock masked and high: the shift register now accepts a write.
    apb(1, `SHIFT_OFS, 32'h3C); apb(0, `SHIFT_OFS, 0); `CHK(rd[7:0], 8'h3C)
    // Slave receive on an external clock with auto acknowledge and busy.
    apb(1, `MODE_OFS, 32'h8);
    apb(1, `CTRL_OFS, 32'h18);
    apb(1, `FIFO_PUSH_OFS, 32'hFF);
    i_peer.clock_byte(8'h96, 10);
    apb(0, `SHIFT_OFS, 0); `CHK(rd[7:0], 8'h96)
    apb(0, `STAT_OFS, 0); `CHK(rd[2], 1'b1)
    `CHK(rd[6], 1'b1)
    `CHK(la_oe, 1'b1)
    apb(1, `CTRL_OFS, 32'h08);
    repeat (4) @(posedge ref_clk);
    `CHK(la_oe, 1'b1)
    i_peer.clock_byte(8'hFF, 1);
    repeat (2) @(posedge ref_clk);
    `CHK(la_oe, 1'b0)
    apb(0, `STAT_OFS, 0); `CHK(rd[6], 1'b0)
    @(posedge ref_clk);
    clk_en <= 1'b0;
    repeat (4) @(posedge ref_clk);
    clk_en <= 1'b1;
    finish_test();
  end
endmodule // serial_bus_if_test
